// ==== verification/core_model.sv ====
// processor core stand-in: instruction boundaries, program counter, call stack
// assumes the unit's call outputs and the bench's core clock and reset
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        call_start_in,
    input  wire logic        call_busy_in,
    input  wire logic [15:0] push_data_in,
    output logic             instr_done_out,
    output logic             ret_out,
    output logic [13:0]      pc_out,
    output logic             carry_out,
    output logic             zero_out,
    output logic [15:0]      pop_data_out
);
    logic [15:0] stack_q [0:7];
    logic [2:0]  sp_q;
    logic [1:0]  phase_q;
    logic        owe_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {sp_q, phase_q, owe_q, ret_out, pc_out} <= '0;
            pop_data_out <= 16'h5A5A;
        end else begin
            phase_q <= phase_q + 2'h1;
            pc_out <= pc_out + 14'h3;
            ret_out <= 1'b0;
            // idle pop data toggles so a stale value never looks valid
            pop_data_out <= ~pop_data_out;
            if (call_start_in) begin
                stack_q[sp_q] <= push_data_in;
                sp_q <= sp_q + 3'h1;
                owe_q <= 1'b1;
            end else if (owe_q && !call_busy_in && !ret_out && phase_q == 2'h2) begin
                ret_out <= 1'b1;
                pop_data_out <= stack_q[sp_q - 3'h1];
                sp_q <= sp_q - 3'h1;
                owe_q <= 1'b0;
            end
        end
    end
    // boundaries never coincide with a return, keeping their effects apart
    assign instr_done_out = phase_q == 2'h0 && !call_busy_in;
    assign carry_out = pc_out[0];
    assign zero_out = pc_out[1];
endmodule : core_model
`default_nettype wire

// ==== verification/irq_rst_unit_props.sv ====
// checker for the interrupt and reset status unit, bound to every irq_rst_unit
// assumes CLK_EN_IN is held high so that every flop moves on each core edge
`timescale 1ns/1ns
`default_nettype none
module irq_rst_props (
    input wire logic        CORE_CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        INSTR_DONE_IN,
    input wire logic        MASK_ALL_INSTR_IN,
    input wire logic        UNMASK_ALL_INSTR_IN,
    input wire logic        RETURN_FROM_SERVICE_INSTR_IN,
    input wire logic [13:0] PC_IN,
    input wire logic        CARRY_FLAG_IN,
    input wire logic        ZERO_FLAG_IN,
    input wire logic [15:0] STACK_POP_DATA_IN,
    input wire logic        CALL_START_OUT,
    input wire logic        CALL_BUSY_OUT,
    input wire logic [13:0] CALL_VECTOR_OUT,
    input wire logic [15:0] STACK_PUSH_DATA_OUT,
    input wire logic        STACK_PUSH_OUT,
    input wire logic        RESTORE_OUT,
    input wire logic [13:0] RESTORE_PC_OUT,
    input wire logic        RESTORE_CARRY_OUT,
    input wire logic        RESTORE_ZERO_OUT,
    input wire logic        GLOBAL_ENABLE_OUT,
    input wire logic        IRQ_PENDING_OUT,
    input wire logic        RUN_OUT,
    input wire logic        SUSPEND_OUT,
    input wire logic        DOG_TIMEOUT_RESET_OUT
);
    // busy run length kept in a small counter, cheaper than unrolling a long repetition
    logic [3:0] busy_cnt_q;
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            busy_cnt_q <= 4'h0;
        end else begin
            busy_cnt_q <= CALL_BUSY_OUT ? busy_cnt_q + 4'h1 : 4'h0;
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    call_at_boundary_a: assert property (CALL_START_OUT |-> $past(INSTR_DONE_IN) &&
        $past(GLOBAL_ENABLE_OUT) && !GLOBAL_ENABLE_OUT) else $error("call off boundary");
    call_length_a: assert property ($fell(CALL_BUSY_OUT) |-> busy_cnt_q == 4'hA)
        else $error("call busy not ten cycles");
    call_cap_a: assert property (CALL_BUSY_OUT |-> busy_cnt_q < 4'hA)
        else $error("call busy too long");
    push_content_a: assert property (CALL_START_OUT |-> STACK_PUSH_OUT &&
        STACK_PUSH_DATA_OUT == {$past(ZERO_FLAG_IN), $past(CARRY_FLAG_IN), $past(PC_IN)})
        else $error("push data");
    vector_slot_a: assert property (CALL_START_OUT |-> CALL_VECTOR_OUT inside {[2:24]} &&
        !CALL_VECTOR_OUT[0] && CALL_VECTOR_OUT != 14'h12) else $error("bad vector");
    return_restore_a: assert property (RETURN_FROM_SERVICE_INSTR_IN && !INSTR_DONE_IN |=>
        RESTORE_OUT && GLOBAL_ENABLE_OUT && {RESTORE_ZERO_OUT, RESTORE_CARRY_OUT,
        RESTORE_PC_OUT} == $past(STACK_POP_DATA_IN)) else $error("return restore");
    unmask_sets_a: assert property (UNMASK_ALL_INSTR_IN && !INSTR_DONE_IN |=>
        GLOBAL_ENABLE_OUT) else $error("unmask lost");
    mask_clears_a: assert property (MASK_ALL_INSTR_IN && !UNMASK_ALL_INSTR_IN &&
        !RETURN_FROM_SERVICE_INSTR_IN |=> !GLOBAL_ENABLE_OUT) else $error("mask lost");
    dog_state_a: assert property (DOG_TIMEOUT_RESET_OUT |-> RUN_OUT && !GLOBAL_ENABLE_OUT &&
        !IRQ_PENDING_OUT && !CALL_BUSY_OUT && !SUSPEND_OUT ##1 !DOG_TIMEOUT_RESET_OUT)
        else $error("dog reset");
    pending_hold_a: assert property ($fell(IRQ_PENDING_OUT) |->
        CALL_START_OUT || DOG_TIMEOUT_RESET_OUT) else $error("pending dropped");
endmodule : irq_rst_props

bind irq_rst_unit irq_rst_props i_props (.CORE_CLK_IN, .ARST_N_IN, .INSTR_DONE_IN,
    .MASK_ALL_INSTR_IN, .UNMASK_ALL_INSTR_IN, .RETURN_FROM_SERVICE_INSTR_IN, .PC_IN,
    .CARRY_FLAG_IN, .ZERO_FLAG_IN, .STACK_POP_DATA_IN, .CALL_START_OUT, .CALL_BUSY_OUT,
    .CALL_VECTOR_OUT, .STACK_PUSH_OUT, .STACK_PUSH_DATA_OUT, .RESTORE_OUT, .RESTORE_PC_OUT,
    .RESTORE_CARRY_OUT, .RESTORE_ZERO_OUT, .GLOBAL_ENABLE_OUT, .IRQ_PENDING_OUT, .RUN_OUT,
    .SUSPEND_OUT, .DOG_TIMEOUT_RESET_OUT);
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for irq_rst_unit: register bus, service chain, watchdog
// assumes core_model as the processor and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    import irq_rst_pkg::*;
    localparam int          LIM   = 64;
    localparam logic [11:0] A_SRC = {2'h0, SRC_EN_IDX, 2'h0};
    localparam logic [11:0] A_EP  = {2'h0, EP_EN_IDX, 2'h0};
    localparam logic [11:0] A_ST  = {2'h0, STATUS_IDX, 2'h0};
    logic        clk, rst_n, awv, wv, bv, brdy, arv, rv, rrdy, awr, wr_rdy, arr, feed, clr;
    logic        unm, msk, idone, ret, cf, zf, cs, busy, gie, pend, dog;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0]  bresp, rresp;
    logic [10:0] evt;
    logic [13:0] pc, vec;
    logic [15:0] pop, pushd;
    logic [3:0]  fc;
    int          err_total, check_count;
    irq_rst_unit #(.WDOG_LIMIT(LIM)) i_dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n),
        .CLK_EN_IN(1'b1), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
        .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wr_rdy),
        .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(brdy), .ARADDR_IN(ara),
        .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rresp),
        .RVALID_OUT(rv), .RREADY_IN(rrdy), .BUS_RESET_EVT_IN(evt[0]),
        .TICK_128US_EVT_IN(evt[1]), .TICK_1MS_EVT_IN(evt[2]), .ENDPOINT_EVT_IN(evt[7:3]),
        .DAC_EVT_IN(evt[8]), .GPIO_EVT_IN(evt[9]), .TWI_EVT_IN(evt[10]),
        .DOG_CLEAR_IN(clr), .DOG_TIMEOUT_RESET_OUT(dog), .INSTR_DONE_IN(idone),
        .MASK_ALL_INSTR_IN(msk), .UNMASK_ALL_INSTR_IN(unm),
        .RETURN_FROM_SERVICE_INSTR_IN(ret), .PC_IN(pc), .CARRY_FLAG_IN(cf),
        .ZERO_FLAG_IN(zf), .STACK_POP_DATA_IN(pop), .CALL_START_OUT(cs),
        .CALL_BUSY_OUT(busy), .CALL_VECTOR_OUT(vec), .STACK_PUSH_OUT(),
        .STACK_PUSH_DATA_OUT(pushd), .RESTORE_OUT(), .RESTORE_PC_OUT(),
        .RESTORE_CARRY_OUT(), .RESTORE_ZERO_OUT(), .GLOBAL_ENABLE_OUT(gie),
        .IRQ_PENDING_OUT(pend), .RUN_OUT(), .SUSPEND_OUT());
    core_model i_core (.clk_in(clk), .rst_n_in(rst_n), .call_start_in(cs),
        .call_busy_in(busy), .push_data_in(pushd), .instr_done_out(idone),
        .ret_out(ret), .pc_out(pc), .carry_out(cf), .zero_out(zf), .pop_data_out(pop));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // firmware clears the watchdog every sixteen cycles while feeding
    always @(posedge clk) begin
        fc <= fc + 4'h1;
        clr <= feed && fc == 4'h0;
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (!bv && n < 100);
        `CHK(bv, 1'b1)
        brdy <= 1'b0;
        `CHK(bresp, er)
    endtask : wr
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 100);
        `CHK(rv, 1'b1)
        rrdy <= 1'b0;
        `CHK(rdat, e)
        `CHK(rresp, er)
    endtask : chk_rd
    task automatic t_regs;
        chk_rd(A_ST, 32'h11, RESP_OKAY);
        chk_rd(A_SRC, 32'h0, RESP_OKAY);
        wr(A_SRC, 8'hFF, RESP_OKAY);
        chk_rd(A_SRC, 32'h77, RESP_OKAY);
        wr(A_EP, 8'hFF, RESP_OKAY);
        chk_rd(A_EP, 32'h1F, RESP_OKAY);
        wr(12'h000, 8'hFF, RESP_SLVERR);
        chk_rd(12'h000, 32'h0, RESP_SLVERR);
        wr(A_ST, 8'h05, RESP_OKAY);
        chk_rd(A_ST, 32'h01, RESP_OKAY);
        unm <= 1'b1;
        @(posedge clk);
        unm <= 1'b0;
        chk_rd(A_ST, 32'h05, RESP_OKAY);
        msk <= 1'b1;
        @(posedge clk);
        msk <= 1'b0;
        chk_rd(A_ST, 32'h01, RESP_OKAY);
        chk_rd(A_EP, 32'h1F, RESP_OKAY);
    endtask : t_regs
    task automatic t_service;
        int k, n, s;
        wr(A_SRC, 8'h57, RESP_OKAY);
        evt <= 11'h7FF;
        @(posedge clk);
        evt <= 11'h000;
        chk_rd(A_ST, 32'hA1, RESP_OKAY);
        unm <= 1'b1;
        @(posedge clk);
        unm <= 1'b0;
        for (k = 0; k < 11; k++) begin
            s = k < 8 ? k : (k == 8 ? 9 : (k == 9 ? 11 : 10));
            if (k == 10) begin
                `CHK(pend, 1'b1)
                wr(A_SRC, 8'h77, RESP_OKAY);
            end
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (!cs && n < 100);
            `CHK(vec, 14'(2 + 2 * s))
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!gie && n < 100);
        chk_rd(A_ST, 32'h25, RESP_OKAY);
    endtask : t_service
    task automatic t_dog(input logic [31:0] e);
        int n;
        n = 0;
        feed <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (!dog && n < 300);
        `CHK(n >= LIM - 16 && n <= LIM + 1, 1'b1)
        feed <= 1'b1;
        chk_rd(A_ST, e, RESP_OKAY);
        chk_rd(A_SRC, 32'h0, RESP_OKAY);
    endtask : t_dog
    initial begin
        {rst_n, awv, wv, brdy, arv, rrdy, unm, msk, clr} = '0;
        {awa, ara, wd, evt, fc, err_total, check_count} = '0;
        feed = 1'b1;
        do_reset();
        t_regs();
        t_service();
        t_dog(32'h61);
        feed <= 1'b0;
        do_reset();
        t_dog(32'h51);
        report_and_stop();
    end
    initial begin
        #(20000 * 4);
        err_total++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// ==== verilog/irq_rst_pkg.sv ====
// constants, state layout and register map of the interrupt and reset status unit
// assumes one 250 MHz core clock and a 12-bit AXI4-Lite byte address
package irq_rst_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0]  SRC_EN_IDX     = 8'h20;
    localparam logic [7:0]  EP_EN_IDX      = 8'h21;
    localparam logic [7:0]  STATUS_IDX     = 8'hFF;
    localparam int          ADDR_W         = 12;

    // writable bits; the rest read as zero
    localparam logic [7:0]  SRC_EN_MASK    = 8'h77;
    localparam logic [7:0]  EP_EN_MASK     = 8'h1F;

    // status bit positions
    localparam int          ST_RUN         = 0;
    localparam int          ST_GIE         = 2;
    localparam int          ST_SUSPEND     = 3;
    localparam int          ST_POR         = 4;
    localparam int          ST_BUSRST      = 5;
    localparam int          ST_WDR         = 6;
    localparam int          ST_PENDING     = 7;

    // source enable bit positions
    localparam int          EN_BUSRST      = 0;
    localparam int          EN_T128        = 1;
    localparam int          EN_T1MS        = 2;
    localparam int          EN_DAC         = 4;
    localparam int          EN_GPIO        = 5;
    localparam int          EN_TWI         = 6;

    // vector slots, index 0 is the bus reset, slot 8 is reserved
    localparam int          NUM_SLOT       = 12;
    localparam logic [13:0] VEC_FIRST      = 14'h0002;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // timing
    localparam int          CLK_MHZ        = 250;
    localparam int          WDOG_TIME_MS   = 8;
    localparam int          WDOG_CYCLES    = WDOG_TIME_MS * CLK_MHZ * 1000;
    localparam logic [3:0]  CALL_CYCLES    = 4'hA;

    typedef enum logic {SVC_IDLE, SVC_CALL} svc_e;

    typedef struct packed {
        logic [NUM_SLOT-1:0] pend;
        logic [7:0]          src_en;
        logic [7:0]          ep_en;
        logic                gie;
        logic                run;
        logic                susp;
        logic                por;
        logic                busrst;
        logic                dog_timeout_reset;
        svc_e                svc;
        logic [3:0]          cyc;
        logic [13:0]         vec;
        logic                push;
        logic [15:0]         push_data;
        logic                restore;
        logic [15:0]         restore_data;
        logic [31:0]         wd_cnt;
        logic                wd_fire;
        logic                aw_have;
        logic [ADDR_W-1:0]   aw_addr;
        logic                w_have;
        logic [31:0]         wdata;
        logic                wlane0;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } unit_s;

    // power-on state: run and power-on cause set, all else clear
    localparam unit_s RESET_STATE = '{run: 1'b1, por: 1'b1, svc: SVC_IDLE, default: '0};

endpackage : irq_rst_pkg

// ==== verilog/irq_rst_unit.sv ====
// interrupt controller with reset-cause status and a watchdog timer
// assumes events are one-cycle pulses from logic on the core clock and that the
// core pulses INSTR_DONE_IN at each instruction boundary
// Summary of operation
// - a watchdog timeout after 8 ms without a clear sets status bit 6
// - status bit 7 shows that at least one source is pending
// - a source stays pending until enabled and serviced; service clears it
// - power-up loads status with 00010001
// - the watchdog also runs during the start-up suspend, giving 01010001
// - a bus reset seen before firmware looks also sets status bit 5
// - watchdog reset loads 01XX0001, keeping power-on and bus-reset bits
// - each source has an enable bit; one enables, zero disables
// - source enable: bus reset, two timers, converter, pins, two-wire; 3,7 reserved
// - endpoint enable bits 0..4 gate endpoints A0,A1,A2,B0,B1
// - power-on and watchdog resets clear both enable registers; a bus reset does not
// - one pending flop per source, held until serviced or reset
// - only an enabled pending source requests service
// - service starts only at the end of the current instruction
// - service clears the global enable and the pending flop and calls the vector on the same edge
// - the global enable reads at status bit 2
// - the call pushes program counter, carry and zero flags
// - return from service restores them and sets the global enable
// - mask and unmask instructions touch only the global enable
// - status bit 7 reflects pending sources while the global enable is clear
// - lowest vector number wins; bus reset first, two-wire last
// - vectors are two bytes apart from 0x0002 up to 0x0018, slot 8 reserved
// - the forced call lasts 10 clock cycles
`timescale 1ns/1ns
`default_nettype none

module irq_rst_unit
    import irq_rst_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    input  wire logic              CORE_CLK_IN,
    input  wire logic              ARST_N_IN,
    input  wire logic              CLK_EN_IN,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] AWADDR_IN,
    input  wire logic              AWVALID_IN,
    output logic                   AWREADY_OUT,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic [3:0]        WSTRB_IN,
    input  wire logic              WVALID_IN,
    output logic                   WREADY_OUT,
    output logic [1:0]             BRESP_OUT,
    output logic                   BVALID_OUT,
    input  wire logic              BREADY_IN,
    input  wire logic [ADDR_W-1:0] ARADDR_IN,
    input  wire logic              ARVALID_IN,
    output logic                   ARREADY_OUT,
    output logic [31:0]            RDATA_OUT,
    output logic [1:0]             RRESP_OUT,
    output logic                   RVALID_OUT,
    input  wire logic              RREADY_IN,
    // source events, one-cycle pulses
    input  wire logic              BUS_RESET_EVT_IN,
    input  wire logic              TICK_128US_EVT_IN,
    input  wire logic              TICK_1MS_EVT_IN,
    input  wire logic [4:0]        ENDPOINT_EVT_IN,
    input  wire logic              DAC_EVT_IN,
    input  wire logic              GPIO_EVT_IN,
    input  wire logic              TWI_EVT_IN,
    // watchdog
    input  wire logic              DOG_CLEAR_IN,
    output logic                   DOG_TIMEOUT_RESET_OUT,
    // processor core
    input  wire logic              INSTR_DONE_IN,
    input  wire logic              MASK_ALL_INSTR_IN,
    input  wire logic              UNMASK_ALL_INSTR_IN,
    input  wire logic              RETURN_FROM_SERVICE_INSTR_IN,
    input  wire logic [13:0]       PC_IN,
    input  wire logic              CARRY_FLAG_IN,
    input  wire logic              ZERO_FLAG_IN,
    input  wire logic [15:0]       STACK_POP_DATA_IN,
    output logic                   CALL_START_OUT,
    output logic                   CALL_BUSY_OUT,
    output logic [13:0]            CALL_VECTOR_OUT,
    output logic                   STACK_PUSH_OUT,
    output logic [15:0]            STACK_PUSH_DATA_OUT,
    output logic                   RESTORE_OUT,
    output logic [13:0]            RESTORE_PC_OUT,
    output logic                   RESTORE_CARRY_OUT,
    output logic                   RESTORE_ZERO_OUT,
    output logic                   GLOBAL_ENABLE_OUT,
    output logic                   IRQ_PENDING_OUT,
    output logic                   RUN_OUT,
    output logic                   SUSPEND_OUT
);

    if (WDOG_LIMIT < 2) begin : g_bad_limit
        $error("WDOG_LIMIT must be at least 2");
    end

    localparam logic [31:0] WD_LAST = 32'(WDOG_LIMIT - 1);

    unit_s               s_q;
    unit_s               s_d;
    logic [NUM_SLOT-1:0] evt;
    logic [NUM_SLOT-1:0] en_map;
    logic [NUM_SLOT-1:0] req;
    logic [3:0]          win_idx;
    logic                win_hit;
    logic [7:0]          status;
    logic [7:0]          rd_idx;
    logic [7:0]          wr_idx;
    logic                rd_map;
    logic                wr_map;

    // slot order sets priority and vector address
    assign evt = {TWI_EVT_IN, GPIO_EVT_IN, DAC_EVT_IN, 1'b0, ENDPOINT_EVT_IN,
                  TICK_1MS_EVT_IN, TICK_128US_EVT_IN, BUS_RESET_EVT_IN};
    assign en_map = {s_q.src_en[EN_TWI], s_q.src_en[EN_GPIO], s_q.src_en[EN_DAC], 1'b0,
                     s_q.ep_en[4:0], s_q.src_en[EN_T1MS], s_q.src_en[EN_T128],
                     s_q.src_en[EN_BUSRST]};
    assign req = s_q.pend & en_map;

    // lowest slot wins
    always_comb begin
        win_idx = 4'h0;
        win_hit = 1'b0;
        for (int i = NUM_SLOT - 1; i >= 0; i--) begin
            if (req[i]) begin
                win_idx = 4'(i);
                win_hit = 1'b1;
            end
        end
    end

    // pending summary ignores the global enable so firmware can poll it
    assign status = {|s_q.pend, s_q.dog_timeout_reset, s_q.busrst, s_q.por, s_q.susp,
                     s_q.gie, 1'b0, s_q.run};

    // decode of word-aligned offsets; low address bits are ignored
    assign rd_idx = ARADDR_IN[9:2];
    assign wr_idx = s_q.aw_addr[9:2];
    assign rd_map = (ARADDR_IN[ADDR_W-1:10] == '0) &&
                    (rd_idx == SRC_EN_IDX || rd_idx == EP_EN_IDX || rd_idx == STATUS_IDX);
    assign wr_map = (s_q.aw_addr[ADDR_W-1:10] == '0) &&
                    (wr_idx == SRC_EN_IDX || wr_idx == EP_EN_IDX || wr_idx == STATUS_IDX);

    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.restore = 1'b0;
        s_d.wd_fire = 1'b0;

        // register bus, write side: address and data may arrive in either order
        if (AWVALID_IN && !s_q.aw_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = AWADDR_IN;
        end
        if (WVALID_IN && !s_q.w_have && !s_q.bvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata = WDATA_IN;
            s_d.wlane0 = WSTRB_IN[0];
        end
        if (s_q.aw_have && s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_map ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wlane0) begin
                case (wr_idx)
                    SRC_EN_IDX: s_d.src_en = s_q.wdata[7:0] & SRC_EN_MASK;
                    EP_EN_IDX:  s_d.ep_en = s_q.wdata[7:0] & EP_EN_MASK;
                    STATUS_IDX: begin
                        // the enable sense and pending bits are not writable
                        s_d.run = s_q.wdata[ST_RUN];
                        s_d.susp = s_q.wdata[ST_SUSPEND];
                        s_d.por = s_q.wdata[ST_POR];
                        s_d.busrst = s_q.wdata[ST_BUSRST];
                        s_d.dog_timeout_reset = s_q.wdata[ST_WDR];
                    end
                    default: ;
                endcase
            end
        end else if (s_q.bvalid && BREADY_IN) begin
            s_d.bvalid = 1'b0;
        end

        // register bus, read side
        if (s_q.rvalid) begin
            if (RREADY_IN) begin
                s_d.rvalid = 1'b0;
            end
        end else if (ARVALID_IN) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = rd_map ? RESP_OKAY : RESP_SLVERR;
            case (rd_idx)
                SRC_EN_IDX: s_d.rdata = {24'h000000, s_q.src_en};
                EP_EN_IDX:  s_d.rdata = {24'h000000, s_q.ep_en};
                STATUS_IDX: s_d.rdata = {24'h000000, status};
                default:    s_d.rdata = 32'h00000000;
            endcase
            if (!rd_map) begin
                s_d.rdata = 32'h00000000;
            end
        end

        // global enable instructions
        if (MASK_ALL_INSTR_IN) begin
            s_d.gie = 1'b0;
        end
        if (UNMASK_ALL_INSTR_IN) begin
            s_d.gie = 1'b1;
        end
        if (RETURN_FROM_SERVICE_INSTR_IN) begin
            s_d.gie = 1'b1;
            s_d.restore = 1'b1;
            s_d.restore_data = STACK_POP_DATA_IN;
        end

        // service sequence
        case (s_q.svc)
            SVC_IDLE: begin
                if (INSTR_DONE_IN && s_q.gie && win_hit) begin
                    s_d.gie = 1'b0;
                    s_d.pend[win_idx] = 1'b0;
                    s_d.vec = VEC_FIRST + {9'h000, win_idx, 1'b0};
                    s_d.push = 1'b1;
                    s_d.push_data = {ZERO_FLAG_IN, CARRY_FLAG_IN, PC_IN};
                    s_d.svc = SVC_CALL;
                    s_d.cyc = 4'h0;
                end
            end
            SVC_CALL: begin
                s_d.cyc = s_q.cyc + 4'h1;
                if (s_q.cyc == CALL_CYCLES - 4'h1) begin
                    s_d.svc = SVC_IDLE;
                end
            end
            default: s_d.svc = SVC_IDLE;
        endcase

        // a new event wins over the service clear of its pending flop
        s_d.pend = s_d.pend | evt;
        if (BUS_RESET_EVT_IN) begin
            s_d.busrst = 1'b1;
        end

        // watchdog: the counter keeps running through the start-up suspend
        if (DOG_CLEAR_IN) begin
            s_d.wd_cnt = 32'h00000000;
        end else begin
            s_d.wd_cnt = s_q.wd_cnt + 32'h00000001;
        end
        if (!DOG_CLEAR_IN && s_q.wd_cnt == WD_LAST) begin
            // whole-unit restart except the power-on and bus-reset causes
            s_d = RESET_STATE;
            s_d.por = s_q.por;
            s_d.busrst = s_q.busrst;
            s_d.dog_timeout_reset = 1'b1;
            s_d.wd_fire = 1'b1;
            s_d.src_en = 8'h00;
            s_d.ep_en = 8'h00;
        end
    end

    // power-on reset loads the status register and clears both enables
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s_q <= RESET_STATE;
        end else if (CLK_EN_IN) begin
            s_q <= s_d;
        end
    end

    assign AWREADY_OUT           = !s_q.aw_have && !s_q.bvalid;
    assign WREADY_OUT            = !s_q.w_have && !s_q.bvalid;
    assign BVALID_OUT            = s_q.bvalid;
    assign BRESP_OUT             = s_q.bresp;
    assign ARREADY_OUT           = !s_q.rvalid;
    assign RVALID_OUT            = s_q.rvalid;
    assign RDATA_OUT             = s_q.rdata;
    assign RRESP_OUT             = s_q.rresp;
    assign DOG_TIMEOUT_RESET_OUT = s_q.wd_fire;
    assign CALL_START_OUT        = s_q.push;
    assign CALL_BUSY_OUT         = (s_q.svc == SVC_CALL);
    assign CALL_VECTOR_OUT       = s_q.vec;
    assign STACK_PUSH_OUT        = s_q.push;
    assign STACK_PUSH_DATA_OUT   = s_q.push_data;
    assign RESTORE_OUT           = s_q.restore;
    assign RESTORE_PC_OUT        = s_q.restore_data[13:0];
    assign RESTORE_CARRY_OUT     = s_q.restore_data[14];
    assign RESTORE_ZERO_OUT      = s_q.restore_data[15];
    assign GLOBAL_ENABLE_OUT     = s_q.gie;
    assign IRQ_PENDING_OUT       = |s_q.pend;
    assign RUN_OUT               = s_q.run;
    assign SUSPEND_OUT           = s_q.susp;

endmodule : irq_rst_unit

`default_nettype wire
